// ### rfsb_pkg.sv
/*
  Package for the regulator fault status bank: command codes, bit positions and reset values.
  Assumes a byte-wide command decoder in front of the bank.
*/
package rfsb_pkg;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_OUT_CURRENT = 8'h7B;
  localparam logic [7:0] CMD_INPUT = 8'h7C;
  localparam logic [7:0] CMD_TEMPERATURE = 8'h7D;
  localparam logic [7:0] CMD_COMM_LOGIC = 8'h7E;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int BIT_OUT_OC_FAULT = 7;
  localparam int BIT_OUT_OC_WARN = 5;
  localparam int BIT_IN_OV_FAULT = 7;
  localparam int BIT_IN_UV_FAULT = 4;
  localparam int BIT_IN_OC_FAULT = 2;
  localparam int BIT_IN_OC_WARN = 1;
  localparam int BIT_OT_FAULT = 7;
  localparam int BIT_OT_WARN = 6;
  // Supported-bit masks; every other bit reads zero
  localparam logic [7:0] MASK_OUT_CURRENT = 8'hA0;
  localparam logic [7:0] MASK_INPUT = 8'h96;
  localparam logic [7:0] MASK_TEMPERATURE = 8'hC0;
  localparam logic [7:0] MASK_COMM_LOGIC = 8'hFF;
endpackage

// ### rfsb_flag_if.sv
/*
  Interface carrying the event and clear strobes of one status byte to its latch.
  Assumes both ends on clk_sys.
*/
`timescale 1ns/1ps
interface rfsb_flag_if;
  logic [7:0] setEvent;
  logic clearAll;
  logic [7:0] flags;
  modport bank (output setEvent, output clearAll, input flags);
  modport latch (input setEvent, input clearAll, output flags);
endinterface

// ### rfsb_flag_latch.sv
/*
  One byte of sticky flags; set wins over clear, masked bits stay zero.
  Assumes synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
module rfsb_flag_latch #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  rfsb_flag_if.latch fl
);
  import rfsb_pkg::*;
  logic [7:0] flagReg;
  logic [7:0] next_flagReg;

  always_comb
  begin
    next_flagReg = flagReg;
    if (fl.clearAll)
    begin
      next_flagReg = RST_STATUS;
    end
    next_flagReg = (next_flagReg | fl.setEvent) & MASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      flagReg <= RST_STATUS;
    end
    else if (clkEn)
    begin
      flagReg <= next_flagReg;
    end
  end

  assign fl.flags = flagReg;
endmodule // rfsb_flag_latch

// ### regulator_fault_status_bank.sv
/*
  Read-only fault status bytes answered by command code; sticky flags set by fault events.
  Assumes event inputs come from logic on clk_sys; reads come from the bus command decoder.
*/
// What this block does
// - Output current byte bit 7 latches output overcurrent fault.
// - Output current byte bit 5 latches output overcurrent warning.
// - Unsupported and reserved bits of the output current, input and temperature bytes always read zero.
// - Code 7Ch returns the input status byte, reset value 00h.
// - Input byte bit 7 latches input overvoltage fault.
// - Input byte bit 4 latches input undervoltage fault.
// - Input byte bit 2 latches input overcurrent fault.
// - Input byte bit 1 latches input overcurrent warning.
// - Code 7Dh returns the temperature status byte, reset value 00h.
// - Temperature byte bit 7 latches overtemperature fault.
// - Temperature byte bit 6 latches overtemperature warning.
// - Code 7Eh returns the communication, logic and memory byte, reset 00h.
// - Code 7Bh returns the output current status byte, reset value 00h.
`timescale 1ns/1ps
module regulator_fault_status_bank (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic outOvercurrentFault,
  input wire logic outOvercurrentWarning,
  input wire logic inOvervoltageFault,
  input wire logic inUndervoltageFault,
  input wire logic inOvercurrentFault,
  input wire logic inOvercurrentWarning,
  input wire logic overtempFault,
  input wire logic overtempWarning,
  input wire logic [7:0] commLogicEvents,
  input wire logic clearFaults,
  input wire logic readStrobe,
  input wire logic [7:0] readCommand,
  output logic [7:0] readData,
  output logic readValid,
  output logic readUnsupported
);
  import rfsb_pkg::*;

  // ----------------------------------------
  // Flag latches
  // ----------------------------------------
  // One carrier per status byte: the bank drives events and clear, the latch returns flags
  rfsb_flag_if outIf();
  rfsb_flag_if inIf();
  rfsb_flag_if tempIf();
  rfsb_flag_if commIf();

  // ----------------------------------------
  // Output current byte
  // ----------------------------------------
  // Unsupported bits get no event here and are masked inside the latch as well
  always_comb
  begin
    outIf.setEvent = 8'h00;
    outIf.setEvent[BIT_OUT_OC_FAULT] = outOvercurrentFault;
    outIf.setEvent[BIT_OUT_OC_WARN] = outOvercurrentWarning;
  end

  assign outIf.clearAll = clearFaults;

  rfsb_flag_latch #(
    .MASK(MASK_OUT_CURRENT)
  ) uOut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .fl(outIf)
  );

  // ----------------------------------------
  // Input byte
  // ----------------------------------------
  always_comb
  begin
    inIf.setEvent = 8'h00;
    inIf.setEvent[BIT_IN_OV_FAULT] = inOvervoltageFault;
    inIf.setEvent[BIT_IN_UV_FAULT] = inUndervoltageFault;
    inIf.setEvent[BIT_IN_OC_FAULT] = inOvercurrentFault;
    inIf.setEvent[BIT_IN_OC_WARN] = inOvercurrentWarning;
  end

  assign inIf.clearAll = clearFaults;

  rfsb_flag_latch #(
    .MASK(MASK_INPUT)
  ) uIn (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .fl(inIf)
  );

  // ----------------------------------------
  // Temperature byte
  // ----------------------------------------
  // Undertemperature and reserved bits have no source and always read zero
  always_comb
  begin
    tempIf.setEvent = 8'h00;
    tempIf.setEvent[BIT_OT_FAULT] = overtempFault;
    tempIf.setEvent[BIT_OT_WARN] = overtempWarning;
  end

  assign tempIf.clearAll = clearFaults;

  rfsb_flag_latch #(
    .MASK(MASK_TEMPERATURE)
  ) uTemp (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .fl(tempIf)
  );

  // ----------------------------------------
  // Communication, logic and memory byte
  // ----------------------------------------
  // Field layout of this byte is owned by the bus logic that raises it
  // Every bit latches, so that logic alone decides which bits can ever be set
  always_comb
  begin
    commIf.setEvent = commLogicEvents;
  end

  assign commIf.clearAll = clearFaults;

  rfsb_flag_latch #(
    .MASK(MASK_COMM_LOGIC)
  ) uComm (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .fl(commIf)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Decode stays apart from the data path so an unknown code can only raise the refusal
  logic hitOut;
  logic hitIn;
  logic hitTemp;
  logic hitComm;
  logic hitAny;

  always_comb
  begin
    hitOut = 1'b0;
    hitIn = 1'b0;
    hitTemp = 1'b0;
    hitComm = 1'b0;
    hitAny = 1'b1;
    unique case (readCommand)
      CMD_OUT_CURRENT: hitOut = 1'b1;
      CMD_INPUT: hitIn = 1'b1;
      CMD_TEMPERATURE: hitTemp = 1'b1;
      CMD_COMM_LOGIC: hitComm = 1'b1;
      default: hitAny = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Reads only sample the latches, so a read can never clear a flag
  logic [7:0] next_readData;
  logic next_readValid;
  logic next_readUnsupported;

  always_comb
  begin
    next_readData = 8'h00;
    next_readValid = 1'b0;
    next_readUnsupported = 1'b0;
    if (readStrobe)
    begin
      next_readValid = 1'b1;
      next_readUnsupported = !hitAny;
      if (hitOut)
      begin
        next_readData = outIf.flags;
      end
      else if (hitIn)
      begin
        next_readData = inIf.flags;
      end
      else if (hitTemp)
      begin
        next_readData = tempIf.flags;
      end
      else if (hitComm)
      begin
        next_readData = commIf.flags;
      end
    end
  end

  // ----------------------------------------
  // Answer register
  // ----------------------------------------
  // Registered so the host sees a clean byte exactly one cycle after its strobe
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      // Reset ignores the enable so the bank always starts from 00h
      readData <= RST_STATUS;
      readValid <= 1'b0;
      readUnsupported <= 1'b0;
    end
    else if (clkEn)
    begin
      // A low enable freezes the answer along with the flags
      readData <= next_readData;
      readValid <= next_readValid;
      readUnsupported <= next_readUnsupported;
    end
  end
endmodule // regulator_fault_status_bank

// ### rfsb_properties.sv
/* Port checker of the fault status bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module rfsb_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic inOvercurrentFault,
  input wire logic overtempFault,
  input wire logic overtempWarning,
  input wire logic clearFaults,
  input wire logic readStrobe,
  input wire logic [7:0] readCommand,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic readUnsupported
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_rd(logic [7:0] c);
    clkEn && readStrobe && readCommand == c;
  endsequence
  a_read_answered: assert property (clkEn && readStrobe |=> readValid)
    else $error("read not answered");
  a_idle_quiet: assert property (clkEn && !readStrobe |=> !readValid && readData == 8'h00)
    else $error("answer without read");
  a_out_unused: assert property (s_rd(8'h7B) |=> (readData & 8'h5F) == 8'h00)
    else $error("out byte unused bit");
  a_in_unused: assert property (s_rd(8'h7C) |=> (readData & 8'h69) == 8'h00)
    else $error("input byte unused bit");
  a_temp_unused: assert property (s_rd(8'h7D) |=> (readData & 8'h3F) == 8'h00)
    else $error("temp byte unused bit");
  a_temp_fault: assert property (clkEn && overtempFault ##1 s_rd(8'h7D) |=> readData[7])
    else $error("temp fault not latched");
  // Two idle cycles apart, so a flag that only follows its input is caught
  a_in_sticky: assert property (clkEn && inOvercurrentFault
    ##1 (clkEn && !clearFaults)[*2] ##1 s_rd(8'h7C) |=> readData[2])
    else $error("input flag not held");
  a_clear_empty: assert property (clkEn && clearFaults
    && !overtempFault && !overtempWarning ##1 s_rd(8'h7D) |=> readData == 8'h00)
    else $error("clear left a flag");
  a_unsup_refused: assert property (clkEn && readStrobe
    && !(readCommand inside {8'h7B, 8'h7C, 8'h7D, 8'h7E})
    |=> readUnsupported && readData == 8'h00)
    else $error("unknown code not refused");
  a_freeze_hold: assert property (!clkEn
    |=> $stable(readData) && $stable(readValid) && $stable(readUnsupported))
    else $error("output moved while frozen");
endmodule // rfsb_properties
bind regulator_fault_status_bank rfsb_properties u_rfsb_properties (.clk_sys, .resetn,
  .clkEn, .inOvercurrentFault, .overtempFault, .overtempWarning, .clearFaults, .readStrobe,
  .readCommand, .readData, .readValid, .readUnsupported);

// ### rfsb_host_model.sv
/* Host issuing one status read at a time.
   Assumes each call starts on a rising edge. */
`timescale 1ns/1ps
module rfsb_host_model (
  input wire logic clk_sys,
  output logic readStrobe,
  output logic [7:0] readCommand,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic readUnsupported
);
  initial readStrobe = 1'b0;
  initial readCommand = 8'h00;
  // Released code is inverted so a stale code never passes for a live one
  task automatic doRead(input logic [7:0] c, output logic [7:0] d, output logic [7:0] s);
    readStrobe <= 1'b1;
    readCommand <= c;
    @(posedge clk_sys);
    readStrobe <= 1'b0;
    readCommand <= ~c;
    @(negedge clk_sys);
    d = readData;
    s = {6'h00, readValid, readUnsupported};
    @(posedge clk_sys);
  endtask
endmodule // rfsb_host_model

// ### tb_top.sv
/* Testbench of the fault status bank.
   Assumes the host model drives reads; stimulus on rising edges. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, readStrobe, readValid, readUnsupported;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic clearFaults = 1'b0;
  logic [15:0] evs = 16'h0000;
  logic [7:0] readCommand, readData, d, s;
  int bad_count, samples_checked, cyc;
  localparam logic [7:0] CODE [8] = '{8'h7B, 8'h7B, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h7D};
  localparam logic [7:0] BITV [8] = '{8'h80, 8'h20, 8'h80, 8'h10, 8'h04, 8'h02, 8'h80, 8'h40};
  regulator_fault_status_bank u_regulator_fault_status_bank (.clk_sys, .resetn, .clkEn,
    .outOvercurrentFault(evs[0]), .outOvercurrentWarning(evs[1]), .inOvervoltageFault(evs[2]),
    .inUndervoltageFault(evs[3]), .inOvercurrentFault(evs[4]), .inOvercurrentWarning(evs[5]),
    .overtempFault(evs[6]), .overtempWarning(evs[7]), .commLogicEvents(evs[15:8]),
    .clearFaults, .readStrobe, .readCommand, .readData, .readValid, .readUnsupported);
  rfsb_host_model host (.clk_sys, .readStrobe, .readCommand, .readData, .readValid,
    .readUnsupported);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic u);
    host.doRead(c, d, s);
    chk(d, e);
    chk(s, {6'h00, 1'b1, u});
  endtask
  task automatic pulse(input logic [15:0] v);
    evs <= v;
    @(posedge clk_sys);
    evs <= 16'h0000;
  endtask
  task automatic final_report;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      final_report;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rd(8'(8'h7B + i), 8'h00, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      pulse(16'h0001 << i);
      rd(CODE[i], BITV[i], 1'b0);
      rd(CODE[i], BITV[i], 1'b0);
      clearFaults <= 1'b1;
      @(posedge clk_sys);
      clearFaults <= 1'b0;
      rd(CODE[i], 8'h00, 1'b0);
    end
    $display("flag test done");
    // A low enable must ignore both a new event and a clear
    pulse(16'h0080);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    clearFaults <= 1'b1;
    pulse(16'h0001);
    clkEn <= 1'b1;
    clearFaults <= 1'b0;
    rd(8'h7D, 8'h40, 1'b0);
    rd(8'h7B, 8'h00, 1'b0);
    $display("freeze test done");
    pulse(16'hA5FF);
    rd(8'h7B, 8'hA0, 1'b0);
    rd(8'h7C, 8'h96, 1'b0);
    rd(8'h7D, 8'hC0, 1'b0);
    rd(8'h7E, 8'hA5, 1'b0);
    rd(8'h7F, 8'h00, 1'b1);
    $display("byte test done");
    final_report;
  end
endmodule // tb_top
